// ---- shared/spac_pkg.sv ----
// constants and types of the speakerphone attenuation control
// How it works
// [RULE_01] tx mode loads receive stage, rx loads transmit
// [RULE_02] idle mode halves loss across both stages
// [RULE_03] tx only on tx detect plus acoustic compare
// [RULE_04] rx only on rx detect plus line compare
// [RULE_05] no speech anywhere moves to idle
// [RULE_06] one byte loss, limited to 95 dB
// [RULE_07] agc gain widens or narrows the loss; code only widens it, any agc above AGC_SPAN leaves the loss unchanged
// [RULE_08] ramps into idle step at decay rate
// [RULE_09] other ramps step at switch rate
// [RULE_10] two bit state field is readable
// [RULE_11] receive agc attenuation readable on request
// [RULE_12] field coded idle/tx/rx, set when ramp completes
package spac_pkg;
   // register indices on the plain register port
   localparam logic [2:0] SPAC_ADDR_LOSS = 3'h0;
   localparam logic [2:0] SPAC_ADDR_DECAY = 3'h1;
   localparam logic [2:0] SPAC_ADDR_SWITCH = 3'h2;
   localparam logic [2:0] SPAC_ADDR_STATUS = 3'h3;
   localparam logic [2:0] SPAC_ADDR_RX_AGC = 3'h4;
   localparam logic [2:0] SPAC_ADDR_TX_LVL = 3'h5;
   localparam logic [2:0] SPAC_ADDR_RX_LVL = 3'h6;
   // reset values and limits
   localparam logic [7:0] SPAC_LOSS_RST = 8'h00;
   localparam logic [7:0] SPAC_LOSS_MAX = 8'h5f;
   localparam logic [7:0] SPAC_DECAY_RST = 8'h01;
   localparam logic [7:0] SPAC_SWITCH_RST = 8'h01;
   // status field codes, fourth code unused
   localparam logic [1:0] SPAC_ST_IDLE = 2'h0;
   localparam logic [1:0] SPAC_ST_TX = 2'h1;
   localparam logic [1:0] SPAC_ST_RX = 2'h2;
   localparam int SPAC_ST_RAMP_BIT = 2;
   // timing: rate code lsb in ns per dB, clock period in ns
   localparam int SPAC_CLK_PERIOD_NS = 100;
   localparam int SPAC_DECAY_UNIT_NS = 2666667;
   localparam int SPAC_SWITCH_UNIT_NS = 39216;
   // cycles per half dB step for one code lsb (round down, min one)
   localparam int SPAC_DECAY_STEP_CYC =
      SPAC_DECAY_UNIT_NS / (2 * SPAC_CLK_PERIOD_NS);
   localparam int SPAC_SWITCH_STEP_CYC =
      SPAC_SWITCH_UNIT_NS / (2 * SPAC_CLK_PERIOD_NS);
   localparam int SPAC_LVL_W = 9;
   typedef enum logic [1:0] {SPAC_IDLE, SPAC_TX, SPAC_RX} spac_mode_type;
endpackage : spac_pkg

// ---- shared/spac_loss_if.sv ----
// stream of stage loss pairs between control core and buffer
interface spac_loss_if #(parameter int W = 9);
   logic valid;
   logic ready;
   logic [W-1:0] tx_loss;
   logic [W-1:0] rx_loss;
   modport src (output valid, output tx_loss, output rx_loss, input ready);
   modport snk (input valid, input tx_loss, input rx_loss, output ready);
endinterface : spac_loss_if

// ---- design/spac_pair_buf.sv ----
// two entry buffer for stage loss pairs, all outputs registered
module spac_pair_buf #(
   parameter int W = 9
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // filling side
   spac_loss_if.snk in_s,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_tx,
   output logic [W-1:0] out_rx
);
   typedef struct packed {
      logic [2*W-1:0] e0;
      logic [2*W-1:0] e1;
      logic v0;
      logic v1;
      logic room;
   } spac_buf_type;
   spac_buf_type q, d;
   logic push, pop;

   // handshakes on both sides
   assign push = in_s.valid & q.room;
   assign pop = q.v0 & out_ready;

   // head shifts on pop, new word lands in first free slot
   always_comb begin
      d = q;
      if (pop) begin
         d.e0 = q.e1;
         d.v0 = q.v1;
         d.v1 = 1'b0;
      end
      if (push) begin
         if (!d.v0) begin
            d.e0 = {in_s.tx_loss, in_s.rx_loss};
            d.v0 = 1'b1;
         end else begin
            d.e1 = {in_s.tx_loss, in_s.rx_loss};
            d.v1 = 1'b1;
         end
      end
      d.room = ~d.v1;
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.room <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_s.ready = q.room;
   assign out_valid = q.v0;
   assign out_tx = q.e0[2*W-1:W];
   assign out_rx = q.e0[W-1:0];
endmodule : spac_pair_buf

// ---- design/spac_top.sv ----
// speakerphone attenuation control: mode choice, loss ramps, registers
//
// Design decisions made here: strobed register access and the register offsets.
module spac_top
   import spac_pkg::*;
#(
   parameter int DECAY_STEP_CYC = SPAC_DECAY_STEP_CYC,
   parameter int SWITCH_STEP_CYC = SPAC_SWITCH_STEP_CYC,
   parameter int AGC_SPAN = 24
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // register port
   input wire logic [2:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // speech detectors and comparators
   input wire logic TX_SPEECH,
   input wire logic ACOUSTIC_SIDE_COMPARATOR,
   input wire logic RX_SPEECH,
   input wire logic LINE_SIDE_COMPARATOR,
   // automatic gain control attenuations in dB
   input wire logic [7:0] TX_AUTO_GAIN,
   input wire logic [7:0] RX_AUTO_GAIN,
   // voice sample ticks
   input wire logic SAMPLE_VALID,
   output logic SAMPLE_READY,
   // stage losses per sample, half dB units
   output logic LOSS_VALID,
   input wire logic LOSS_READY,
   output logic [SPAC_LVL_W-1:0] TX_LOSS_STAGE,
   output logic [SPAC_LVL_W-1:0] RX_LOSS_STAGE
);
   localparam int LW = SPAC_LVL_W;
   localparam logic [LW-1:0] LVL_MAX = '1;

   typedef struct packed {
      logic [7:0] switchable_loss;
      logic [7:0] decay_rate;
      logic [7:0] switch_rate;
      spac_mode_type mode;
      logic [1:0] speaker_state_field;
      logic [LW-1:0] tx_lvl;
      logic [LW-1:0] rx_lvl;
      logic [23:0] timer;
      logic [7:0] rdata;
   } spac_core_type;
   spac_core_type q, d;

   spac_loss_if #(.W(LW)) loss_s ();

   logic [9:0] eff_wide;
   logic [LW-1:0] eff2;
   logic [LW-1:0] tx_tgt, rx_tgt;
   logic [23:0] period;
   logic [7:0] rate;
   logic at_tgt, tick;
   logic [1:0] mode_code;
   spac_mode_type mode_nx;

   // effective loss grows with agc gain unless either agc exceeds AGC_SPAN, saturating in half dB
   always_comb begin
      eff_wide = 10'({2'h0, q.switchable_loss})
         + 10'(AGC_SPAN) - 10'({2'h0, TX_AUTO_GAIN})
         + 10'(AGC_SPAN) - 10'({2'h0, RX_AUTO_GAIN}); // see [RULE_07]
      if (TX_AUTO_GAIN > 8'(AGC_SPAN) || RX_AUTO_GAIN > 8'(AGC_SPAN)) begin
         eff_wide = 10'({2'h0, q.switchable_loss});
      end
      if (eff_wide > 10'(LVL_MAX >> 1)) begin
         eff2 = LVL_MAX - 9'h001;
      end else begin
         eff2 = LW'({eff_wide[8:0], 1'b0});
      end
   end

   // stage targets per mode
   always_comb begin
      case (q.mode)
         SPAC_TX: begin
            tx_tgt = '0;
            rx_tgt = eff2; // see [RULE_01]
            mode_code = SPAC_ST_TX;
         end
         SPAC_RX: begin
            tx_tgt = eff2; // see [RULE_01]
            rx_tgt = '0;
            mode_code = SPAC_ST_RX;
         end
         default: begin
            tx_tgt = eff2 >> 1; // see [RULE_02]
            rx_tgt = eff2 >> 1;
            mode_code = SPAC_ST_IDLE;
         end
      endcase
   end

   // mode decision from detectors and comparators
   always_comb begin
      mode_nx = q.mode;
      if (TX_SPEECH && ACOUSTIC_SIDE_COMPARATOR) begin
         mode_nx = SPAC_TX; // see [RULE_03]
      end else if (RX_SPEECH && LINE_SIDE_COMPARATOR) begin
         mode_nx = SPAC_RX; // see [RULE_04]
      end else if (!TX_SPEECH && !RX_SPEECH) begin
         mode_nx = SPAC_IDLE; // see [RULE_05]
      end
   end

   // ramp period per half dB step
   always_comb begin
      if (q.mode == SPAC_IDLE) begin
         rate = (q.decay_rate == 8'h00) ? 8'h01 : q.decay_rate;
         period = 24'(int'(rate) * DECAY_STEP_CYC); // see [RULE_08]
      end else begin
         rate = (q.switch_rate == 8'h00) ? 8'h01 : q.switch_rate;
         period = 24'(int'(rate) * SWITCH_STEP_CYC); // see [RULE_09]
      end
      if (period == 24'h000000) begin
         period = 24'h000001;
      end
   end

   assign at_tgt = (q.tx_lvl == tx_tgt) && (q.rx_lvl == rx_tgt);
   assign tick = !at_tgt && (q.timer >= period - 24'h000001);

   // next state: registers, mode, ramp, read data
   always_comb begin
      d = q;
      d.rdata = 8'h00;
      if (REG_WR) begin
         case (REG_ADDR)
            SPAC_ADDR_LOSS: begin
               d.switchable_loss = (REG_WDATA > SPAC_LOSS_MAX) ?
                  SPAC_LOSS_MAX : REG_WDATA; // see [RULE_06]
            end
            SPAC_ADDR_DECAY: d.decay_rate = REG_WDATA;
            SPAC_ADDR_SWITCH: d.switch_rate = REG_WDATA;
            default: d.rdata = 8'h00;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            SPAC_ADDR_LOSS: d.rdata = q.switchable_loss;
            SPAC_ADDR_DECAY: d.rdata = q.decay_rate;
            SPAC_ADDR_SWITCH: d.rdata = q.switch_rate;
            SPAC_ADDR_STATUS: begin // see [RULE_10]
               d.rdata = {5'h00, !at_tgt, q.speaker_state_field};
            end
            SPAC_ADDR_RX_AGC: d.rdata = RX_AUTO_GAIN; // see [RULE_11]
            SPAC_ADDR_TX_LVL: d.rdata = q.tx_lvl[LW-1:1];
            SPAC_ADDR_RX_LVL: d.rdata = q.rx_lvl[LW-1:1];
            default: d.rdata = 8'h00;
         endcase
      end
      d.mode = mode_nx;
      // ramp timer restarts when a mode change moves the goal
      if (at_tgt || mode_nx != q.mode || tick) begin
         d.timer = '0;
      end else begin
         d.timer = q.timer + 24'h000001;
      end
      // one half dB per tick toward the target on each stage
      if (tick) begin
         if (q.tx_lvl < tx_tgt) begin
            d.tx_lvl = q.tx_lvl + 9'h001;
         end else if (q.tx_lvl > tx_tgt) begin
            d.tx_lvl = q.tx_lvl - 9'h001;
         end
         if (q.rx_lvl < rx_tgt) begin
            d.rx_lvl = q.rx_lvl + 9'h001;
         end else if (q.rx_lvl > rx_tgt) begin
            d.rx_lvl = q.rx_lvl - 9'h001;
         end
      end
      // state field follows mode once both stages settle
      if (at_tgt) begin
         d.speaker_state_field = mode_code; // see [RULE_12]
      end
   end

   // state register
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         q <= '0;
         q.switchable_loss <= SPAC_LOSS_RST;
         q.decay_rate <= SPAC_DECAY_RST;
         q.switch_rate <= SPAC_SWITCH_RST;
         q.mode <= SPAC_IDLE;
         q.speaker_state_field <= SPAC_ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // each accepted sample carries the present stage losses
   assign loss_s.valid = SAMPLE_VALID;
   assign loss_s.tx_loss = q.tx_lvl;
   assign loss_s.rx_loss = q.rx_lvl;
   assign SAMPLE_READY = loss_s.ready;
   assign REG_RDATA = q.rdata;

   spac_pair_buf #(.W(LW)) u_buf (
      .clk(CORE_CLK),
      .resetn(RESETN),
      .in_s(loss_s),
      .out_valid(LOSS_VALID),
      .out_ready(LOSS_READY),
      .out_tx(TX_LOSS_STAGE),
      .out_rx(RX_LOSS_STAGE)
   );

   // checks
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);

   property p_targets_tx;
      q.mode == SPAC_TX |-> tx_tgt == '0 && rx_tgt == eff2;
   endproperty
   a_targets_tx: assert property (p_targets_tx) // see [RULE_01]
      else $error("tx mode targets wrong");

   property p_idle_split;
      q.mode == SPAC_IDLE |-> tx_tgt == rx_tgt && tx_tgt == (eff2 >> 1);
   endproperty
   a_idle_split: assert property (p_idle_split) // see [RULE_02]
      else $error("idle split wrong");

   property p_tx_entry;
      (q.mode == SPAC_TX && $past(q.mode) != SPAC_TX)
         |-> $past(TX_SPEECH && ACOUSTIC_SIDE_COMPARATOR);
   endproperty
   a_tx_entry: assert property (p_tx_entry) // see [RULE_03]
      else $error("tx entered without cause");

   property p_rx_entry;
      (q.mode == SPAC_RX && $past(q.mode) != SPAC_RX)
         |-> $past(RX_SPEECH && LINE_SIDE_COMPARATOR);
   endproperty
   a_rx_entry: assert property (p_rx_entry) // see [RULE_04]
      else $error("rx entered without cause");

   property p_to_idle;
      (!TX_SPEECH && !RX_SPEECH) |=> q.mode == SPAC_IDLE;
   endproperty
   a_to_idle: assert property (p_to_idle) // see [RULE_05]
      else $error("silence did not give idle");

   property p_loss_limit;
      REG_WR && REG_ADDR == SPAC_ADDR_LOSS && REG_WDATA > SPAC_LOSS_MAX
         |=> q.switchable_loss == SPAC_LOSS_MAX;
   endproperty
   a_loss_limit: assert property (p_loss_limit) // see [RULE_06]
      else $error("loss not limited");

   property p_loss_kept;
      REG_WR && REG_ADDR == SPAC_ADDR_LOSS && REG_WDATA <= SPAC_LOSS_MAX
         |=> q.switchable_loss == $past(REG_WDATA);
   endproperty
   a_loss_kept: assert property (p_loss_kept) // see [RULE_06]
      else $error("legal loss not stored");

   property p_agc_widen;
      TX_AUTO_GAIN < 8'(AGC_SPAN) && RX_AUTO_GAIN <= 8'(AGC_SPAN)
         |-> eff2 > LW'({q.switchable_loss, 1'b0});
   endproperty
   a_agc_widen: assert property (p_agc_widen) // see [RULE_07]
      else $error("agc gain did not widen loss");

   property p_decay_period;
      q.mode == SPAC_IDLE && !at_tgt && q.decay_rate == 8'h02
         |-> period == 24'(2 * DECAY_STEP_CYC);
   endproperty
   a_decay_period: assert property (p_decay_period) // see [RULE_08]
      else $error("decay period wrong");

   property p_switch_period;
      q.mode != SPAC_IDLE && !at_tgt && q.switch_rate == 8'h01
         |-> period == 24'(SWITCH_STEP_CYC);
   endproperty
   a_switch_period: assert property (p_switch_period) // see [RULE_09]
      else $error("switch period wrong");

   property p_step_paced;
      ($changed(q.tx_lvl) || $changed(q.rx_lvl)) |-> $past(tick);
   endproperty
   a_step_paced: assert property (p_step_paced) // see [RULE_09]
      else $error("stage moved off tick");

   property p_field_update;
      at_tgt |=> q.speaker_state_field == $past(mode_code);
   endproperty
   a_field_update: assert property (p_field_update) // see [RULE_12]
      else $error("state field stale");

   property p_status_read;
      REG_RD && REG_ADDR == SPAC_ADDR_STATUS
         |=> REG_RDATA[1:0] == $past(q.speaker_state_field);
   endproperty
   a_status_read: assert property (p_status_read) // see [RULE_10]
      else $error("status read wrong");

   property p_agc_read;
      REG_RD && REG_ADDR == SPAC_ADDR_RX_AGC
         |=> REG_RDATA == $past(RX_AUTO_GAIN);
   endproperty
   a_agc_read: assert property (p_agc_read) // see [RULE_11]
      else $error("rx agc read wrong");
endmodule : spac_top

// ---- dv/spac_voice_model.sv ----
// far side model: voice sample ticks out, stage loss words in
module spac_voice_model
   import spac_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bench control
   input wire logic send,
   input wire logic stall,
   // sample tick handshake
   output logic sample_valid,
   input wire logic sample_ready,
   // loss word handshake
   input wire logic loss_valid,
   output logic loss_ready,
   input wire logic [SPAC_LVL_W-1:0] tx_in,
   input wire logic [SPAC_LVL_W-1:0] rx_in,
   // last word taken and word count
   output logic [SPAC_LVL_W-1:0] last_tx,
   output logic [SPAC_LVL_W-1:0] last_rx,
   output int words
);
   timeunit 1ns;
   timeprecision 1ns;

   // tick held until taken, words taken only when ready
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sample_valid <= 1'b0;
         loss_ready <= 1'b0;
         last_tx <= '0;
         last_rx <= '0;
         words <= 0;
      end else begin
         sample_valid <= send || (sample_valid && !sample_ready);
         loss_ready <= !stall;
         if (loss_valid && loss_ready) begin
            last_tx <= tx_in;
            last_rx <= rx_in;
            words <= words + 1;
         end
      end
   end
endmodule : spac_voice_model

// ---- dv/spac_top_tb_top.sv ----
// self-checking bench of the speakerphone attenuation control
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module spac_top_tb_top
   import spac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SPAN = 24;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic txs = 1'b0;
   logic acmp = 1'b0;
   logic rxs = 1'b0;
   logic lcmp = 1'b0;
   logic [7:0] tx_agc = 8'h18;
   logic [7:0] rx_agc = 8'h18;
   logic sv, sr, lv, lr, send = 1'b0, stall = 1'b0;
   logic [8:0] tx_l, rx_l, ltx, lrx;
   int words, w0, fails = 0, compares = 0, cyc = 0;

   // design with shortened step periods
   spac_top #(.DECAY_STEP_CYC(4), .SWITCH_STEP_CYC(2), .AGC_SPAN(SPAN))
   u_dut (.CORE_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .TX_SPEECH(txs), .ACOUSTIC_SIDE_COMPARATOR(acmp), .RX_SPEECH(rxs),
      .LINE_SIDE_COMPARATOR(lcmp), .TX_AUTO_GAIN(tx_agc),
      .RX_AUTO_GAIN(rx_agc), .SAMPLE_VALID(sv), .SAMPLE_READY(sr),
      .LOSS_VALID(lv), .LOSS_READY(lr), .TX_LOSS_STAGE(tx_l),
      .RX_LOSS_STAGE(rx_l));

   // far side
   spac_voice_model u_far (.clk(clk), .resetn(rst_n), .send(send),
      .stall(stall), .sample_valid(sv), .sample_ready(sr),
      .loss_valid(lv), .loss_ready(lr), .tx_in(tx_l), .rx_in(rx_l),
      .last_tx(ltx), .last_rx(lrx), .words(words));

   // 100 ns clock and hang limit
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   // read data stands only in the cycle after the strobe
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask : rchk

   task automatic sp(input logic t, a, r, l);
      @(posedge clk);
      txs <= t;
      acmp <= a;
      rxs <= r;
      lcmp <= l;
   endtask : sp

   // one sample tick, then compare the loss word it returned
   task automatic samp(input logic [8:0] et, er);
      @(posedge clk);
      w0 = words;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      for (int i = 0; i < 20 && words == w0; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK("words", w0 + 1, words)
      `CHK("tx_stage", et, ltx)
      `CHK("rx_stage", er, lrx)
   endtask : samp

   initial begin
      wt(3);
      @(posedge clk) rst_n <= 1'b1;
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_IDLE});
      rchk(SPAC_ADDR_LOSS, SPAC_LOSS_RST);
      rchk(SPAC_ADDR_DECAY, SPAC_DECAY_RST);
      rchk(SPAC_ADDR_SWITCH, SPAC_SWITCH_RST);
      wreg(SPAC_ADDR_LOSS, 8'hff);
      rchk(SPAC_ADDR_LOSS, SPAC_LOSS_MAX);
      wreg(SPAC_ADDR_LOSS, 8'h0a);
      wt(100);
      samp(9'h00a, 9'h00a);
      // tx speech without the comparator keeps idle
      sp(1'b1, 1'b0, 1'b0, 1'b0);
      wt(60);
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_IDLE});
      sp(1'b1, 1'b1, 1'b0, 1'b0);
      wt(30);
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_TX});
      samp(9'h000, 9'h014);
      rchk(SPAC_ADDR_RX_LVL, 8'h0a);
      // rx speech without the comparator holds transmit
      sp(1'b0, 1'b0, 1'b1, 1'b0);
      wt(60);
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_TX});
      sp(1'b0, 1'b0, 1'b1, 1'b1);
      wt(60);
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_RX});
      samp(9'h014, 9'h000);
      rchk(SPAC_ADDR_TX_LVL, 8'h0a);
      // silence decays slowly toward idle
      sp(1'b0, 1'b0, 1'b0, 1'b0);
      wt(25);
      rchk(SPAC_ADDR_STATUS, {5'h00, 1'b1, SPAC_ST_RX});
      wt(40);
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_IDLE});
      samp(9'h00a, 9'h00a);
      // agc gain widens the loss range
      @(posedge clk);
      tx_agc <= 8'h14;
      rx_agc <= 8'h11;
      wt(80);
      samp(9'h015, 9'h015);
      rchk(SPAC_ADDR_RX_AGC, 8'h11);
      @(posedge clk);
      tx_agc <= 8'(SPAN);
      rx_agc <= 8'(SPAN);
      // unmapped read and read-only write, ramp back still running
      rchk(3'h7, 8'h00);
      wreg(SPAC_ADDR_STATUS, 8'h02);
      rchk(SPAC_ADDR_STATUS, {5'h00, 1'b1, SPAC_ST_IDLE});
      // fill the buffer under stall, then drain
      @(posedge clk);
      w0 = words;
      stall <= 1'b1;
      send <= 1'b1;
      wt(10);
      #1;
      `CHK("sample_ready", 1'b0, sr)
      `CHK("loss_valid", 1'b1, lv)
      @(posedge clk);
      send <= 1'b0;
      stall <= 1'b0;
      wt(12);
      #1;
      `CHK("words", w0 + 3, words)
      `CHK("loss_valid", 1'b0, lv)
      // let the narrowing ramp finish
      wt(20);
      samp(9'h00a, 9'h00a);
      // doubled decay code halves the pace into idle
      wreg(SPAC_ADDR_DECAY, 8'h02);
      rchk(SPAC_ADDR_DECAY, 8'h02);
      sp(1'b1, 1'b1, 1'b0, 1'b0);
      wt(30);
      sp(1'b0, 1'b0, 1'b0, 1'b0);
      wt(45);
      rchk(SPAC_ADDR_STATUS, {5'h00, 1'b1, SPAC_ST_TX});
      wt(40);
      rchk(SPAC_ADDR_STATUS, {6'h00, SPAC_ST_IDLE});
      stop_test();
   end
endmodule : spac_top_tb_top
